/* rtl/fpe_regs.svh */
// Timing and geometry constants of the flash programming-port entry block.
// Assumes a 200 MHz core clock; included by the timer and top design files.
`ifndef FPE_REGS_SVH
`define FPE_REGS_SVH
`define FPE_CLK_MHZ 200
`define FPE_WRITE_MAX_US 21
`define FPE_PAGE_ERASE_MAX_MS 21
`define FPE_MASS_ERASE_MAX_MS 21
`define FPE_ENTER_MIN_US 125
`define FPE_EXIT_MIN_US 10
`define FPE_WRITE_CYC (`FPE_WRITE_MAX_US * `FPE_CLK_MHZ)
`define FPE_PAGE_CYC (`FPE_PAGE_ERASE_MAX_MS * 1000 * `FPE_CLK_MHZ)
`define FPE_MASS_CYC (`FPE_MASS_ERASE_MAX_MS * 1000 * `FPE_CLK_MHZ)
`define FPE_OP_NONE 2'h0
`define FPE_OP_WRITE 2'h1
`define FPE_OP_PAGE 2'h2
`define FPE_OP_MASS 2'h3
`define FPE_SYNC_STAGES 2
`define FPE_PIN_COUNT 5
`define FPE_PIN_IDLE 5'h07
`define FPE_PIN_RESET 0
`define FPE_PIN_ENABLE 1
`define FPE_PIN_SELECT 2
`define FPE_PIN_SCLK 3
`define FPE_PIN_DATA 4
`endif

/* rtl/fpe_pkg.sv */
// Types shared by the flash programming-port entry design files.
// Assumes fpe_regs.svh supplies the numeric constants.
package fpe_pkg;
    typedef enum logic [1:0] {FPE_RUN, FPE_PROG, FPE_EXIT} fpe_mode_t;
    typedef enum logic [1:0] {FPE_IDLE, FPE_BUSY} fpe_op_t;
endpackage : fpe_pkg

/* rtl/fpe_flash_timer.sv */
// Flash operation timer: holds busy for a bounded count per operation kind.
// Assumes start pulses and kind come from logic on the same clock.
`include "fpe_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_timer #(
    parameter int unsigned WRITE_CYC = `FPE_WRITE_CYC,
    parameter int unsigned PAGE_CYC = `FPE_PAGE_CYC,
    parameter int unsigned MASS_CYC = `FPE_MASS_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Request
    input wire logic start,
    input wire logic [1:0] kind,
    // Status
    output logic busy,
    output logic done
);
    fpe_pkg::fpe_op_t state_r;
    logic [31:0] count_r;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_r <= fpe_pkg::FPE_IDLE;
            count_r <= 32'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                fpe_pkg::FPE_IDLE: begin
                    if (start && kind != `FPE_OP_NONE) begin
                        state_r <= fpe_pkg::FPE_BUSY;
                        // Full budget used; real cells finish sooner, never later
                        case (kind)
                            `FPE_OP_WRITE: count_r <= WRITE_CYC - 1; // see RULE_01
                            `FPE_OP_PAGE: count_r <= PAGE_CYC - 1; // see RULE_02
                            default: count_r <= MASS_CYC - 1; // see RULE_03
                        endcase
                    end
                end
                fpe_pkg::FPE_BUSY: begin
                    if (count_r == 32'h0) begin
                        state_r <= fpe_pkg::FPE_IDLE;
                        done <= 1'b1;
                    end else begin
                        count_r <= count_r - 32'h1;
                    end
                end
                default: state_r <= fpe_pkg::FPE_IDLE;
            endcase
        end
    end

    assign busy = (state_r == fpe_pkg::FPE_BUSY);
endmodule : fpe_flash_timer
`default_nettype wire

/* rtl/fpe_top.sv */
// Flash programming-port entry: mode detection, fetch stall, op timing.
// Assumes pins are asynchronous to core_clk; serial protocol decode lies elsewhere.
// Function
// RULE_01 - Word write finishes within 21 us
// RULE_02 - Page erase finishes within 21 ms
// RULE_03 - Bank mass erase finishes within 21 ms
// RULE_04 - Busy bank stalls instruction fetches
// RULE_05 - Programmer asserts enable before reset
// RULE_06 - Programmer waits 125 us before select
// RULE_07 - Programmer waits 10 us before exit
// RULE_08 - Module reset is active low
// RULE_09 - Processor held inactive in programming mode
`include "fpe_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module fpe_top #(
    parameter int unsigned BANKS = 2,
    parameter int unsigned WRITE_CYC = `FPE_WRITE_CYC,
    parameter int unsigned PAGE_CYC = `FPE_PAGE_CYC,
    parameter int unsigned MASS_CYC = `FPE_MASS_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Programmer pins
    input wire logic module_reset_n,
    input wire logic flash_program_enable_n,
    input wire logic prog_port_select_n,
    input wire logic prog_port_serial_clock,
    input wire logic prog_port_data_in,
    // Flash operation requests: start per bank, kind shared by all banks
    input wire logic [BANKS-1:0] opStart,
    input wire logic [1:0] opKind,
    // Status and control outputs
    output logic progMode,
    output logic cpuHold,
    output logic [BANKS-1:0] bankBusy,
    output logic [BANKS-1:0] fetchStall,
    output logic [BANKS-1:0] opDone,
    output logic serialEdge,
    output logic serialBit
);

    // Local copy of the board reset; every other flop in the block uses it
    // Assertion is immediate, release waits two edges
    logic rstSync1_r;
    logic rstN_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstN_r <= 1'b0;
        end else begin
            rstN_r <= rstSync1_r;
        end
    end

    // Pins gathered in one vector so that one loop builds every synchroniser
    // Limitation: a pin pulse shorter than one clock may be missed
    // Reset, enable and select idle high; serial clock and data idle low
    localparam int PINS = `FPE_PIN_COUNT;
    localparam logic [PINS-1:0] PIN_IDLE = `FPE_PIN_IDLE;
    wire logic [PINS-1:0] pinRaw;
    wire logic [PINS-1:0] pinSync;
    logic mrstN;
    logic penN;
    logic selN;
    logic sck;
    logic mosi;

    assign pinRaw[`FPE_PIN_RESET] = module_reset_n;
    assign pinRaw[`FPE_PIN_ENABLE] = flash_program_enable_n;
    assign pinRaw[`FPE_PIN_SELECT] = prog_port_select_n;
    assign pinRaw[`FPE_PIN_SCLK] = prog_port_serial_clock;
    assign pinRaw[`FPE_PIN_DATA] = prog_port_data_in;

    // Flops start at each pin's idle level, so no false edge follows reset
    genvar p;
    generate
        for (p = 0; p < PINS; p++) begin : gSync
            logic stageA_r;
            logic stageB_r;
            always_ff @(posedge core_clk or negedge rstN_r) begin
                if (!rstN_r) begin
                    stageA_r <= PIN_IDLE[p];
                    stageB_r <= PIN_IDLE[p];
                end else begin
                    stageA_r <= pinRaw[p];
                    stageB_r <= stageA_r;
                end
            end
            // Only the second stage is ever read
            assign pinSync[p] = stageB_r;
        end
    endgenerate

    assign mrstN = pinSync[`FPE_PIN_RESET];
    assign penN = pinSync[`FPE_PIN_ENABLE];
    assign selN = pinSync[`FPE_PIN_SELECT];
    assign sck = pinSync[`FPE_PIN_SCLK];
    assign mosi = pinSync[`FPE_PIN_DATA];

    // Mode tracking; entry needs both lines low
    // A reset alone only holds the processor; it never opens the port
    fpe_pkg::fpe_mode_t mode_r;
    always_ff @(posedge core_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            mode_r <= fpe_pkg::FPE_RUN;
        end else begin
            case (mode_r)
                fpe_pkg::FPE_RUN: begin
                    if (!mrstN && !penN) begin
                        mode_r <= fpe_pkg::FPE_PROG; // see RULE_05, RULE_08
                    end
                end
                fpe_pkg::FPE_PROG: begin
                    // Leaving needs both lines released; the quiet gap is on the programmer
                    if (mrstN && penN) begin
                        mode_r <= fpe_pkg::FPE_EXIT; // see RULE_07
                    end
                end
                fpe_pkg::FPE_EXIT: begin
                    mode_r <= fpe_pkg::FPE_RUN;
                end
                default: mode_r <= fpe_pkg::FPE_RUN;
            endcase
        end
    end

    assign progMode = (mode_r == fpe_pkg::FPE_PROG);
    // Processor held while module reset low or programming; see RULE_08, RULE_09
    assign cpuHold = progMode || !mrstN;

    // Select is trusted only once reset has been low for the enter wait.
    // The count runs on the synchronised line, so the sync stages come off
    // the target and a punctual programmer is never refused.
    localparam int SYNC = `FPE_SYNC_STAGES;
    localparam int ENTER_CYC = `FPE_ENTER_MIN_US * `FPE_CLK_MHZ - SYNC;
    localparam int ENTER_W = $clog2(ENTER_CYC + 1);
    localparam logic [ENTER_W-1:0] ENTER_END = ENTER_W'(ENTER_CYC);
    logic [ENTER_W-1:0] enterCount_r;
    logic enterDone;
    logic selTrusted;

    always_ff @(posedge core_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            enterCount_r <= '0;
        end else if (mrstN) begin
            enterCount_r <= '0;
        end else if (enterCount_r != ENTER_END) begin
            enterCount_r <= enterCount_r + 1'b1;
        end
    end

    assign enterDone = (enterCount_r == ENTER_END);
    assign selTrusted = progMode && !selN && enterDone; // see RULE_06

    // Edges are found on the core clock, so the serial clock must stay far slower
    // Serial clock rests low, matching the flop's reset value
    logic sckPrev_r;
    logic sckRise;
    assign sckRise = sck && !sckPrev_r;

    always_ff @(posedge core_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            sckPrev_r <= 1'b0;
        end else begin
            sckPrev_r <= sck;
        end
    end

    always_ff @(posedge core_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            serialEdge <= 1'b0;
        end else begin
            serialEdge <= selTrusted && sckRise; // see RULE_06
        end
    end

    // Captured bit holds until the next accepted edge
    always_ff @(posedge core_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            serialBit <= 1'b0;
        end else if (selTrusted && sckRise) begin
            serialBit <= mosi;
        end
    end

    // Each bank owns a timer, so work on one bank leaves the other fetching
    genvar b;
    generate
        for (b = 0; b < BANKS; b++) begin : gBank
            logic startValid;
            assign startValid = opStart[b] && opKind != `FPE_OP_NONE;

            fpe_flash_timer #(
                .WRITE_CYC(WRITE_CYC),
                .PAGE_CYC(PAGE_CYC),
                .MASS_CYC(MASS_CYC)
            ) uTimer (
                .clk(core_clk),
                .rstN(rstN_r),
                .start(opStart[b]),
                .kind(opKind),
                .busy(bankBusy[b]),
                .done(opDone[b])
            );

            // Stall also covers the start cycle so no fetch slips in
            assign fetchStall[b] = bankBusy[b] || startValid; // see RULE_04
        end
    endgenerate
endmodule : fpe_top
`default_nettype wire

/* verification/fpe_top_chk.sv */
// Checker of fpe_top op timing, fetch stall and mode outputs.
// Assumes a bind with the shortened op counts and two banks.
`timescale 1ns/1ps
`default_nettype none
module fpe_top_chk #(
    parameter int WRITE_CYC = 20,
    parameter int PAGE_CYC = 50,
    parameter int MASS_CYC = 60
) (
    // Clock, reset, pin
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic module_reset_n,
    // Ops
    input wire logic [1:0] opStart,
    input wire logic [1:0] opKind,
    // Status
    input wire logic progMode,
    input wire logic cpuHold,
    input wire logic [1:0] bankBusy,
    input wire logic [1:0] fetchStall,
    input wire logic [1:0] opDone
);
    localparam int W1 = WRITE_CYC + 1;
    localparam int P1 = PAGE_CYC + 1;
    localparam int M1 = MASS_CYC + 1;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire logic go = opStart[0] && !bankBusy[0];
    property p_wr; go && opKind == 2'h1 |-> ##W1 opDone[0]; endproperty
    a_wr: assert property (p_wr) else $error("write end off");
    property p_pg; go && opKind == 2'h2 |-> ##P1 opDone[0]; endproperty
    a_pg: assert property (p_pg) else $error("page erase end off");
    property p_ms; go && opKind == 2'h3 |-> ##M1 opDone[0]; endproperty
    a_ms: assert property (p_ms) else $error("mass erase end off");
    property p_st; go && opKind != 2'h0 |-> fetchStall[0] ##1 bankBusy[0] && fetchStall[0];
    endproperty
    a_st: assert property (p_st) else $error("fetch not stalled");
    property p_hd; progMode |-> cpuHold; endproperty
    a_hd: assert property (p_hd) else $error("cpu runs in mode");
    // Five cycles covers the two-stage pin sync with margin
    property p_rs; !module_reset_n [*5] |-> cpuHold; endproperty
    a_rs: assert property (p_rs) else $error("reset low ignored");
    property p_en; $rose(progMode) |-> !$past(module_reset_n, 3); endproperty
    a_en: assert property (p_en) else $error("mode without reset");
    cover property (opDone[1]);
    cover property ($rose(progMode));
    cover property (go && opKind == 2'h3);
endmodule : fpe_top_chk
`default_nettype wire

/* verification/fpe_prog_model.sv */
// Programmer model: mode entry and exit pins and serial frames.
// Assumes the bench calls its tasks; serial clock rests low between frames.
`timescale 1ns/1ps
`default_nettype none
module fpe_prog_model (
    // Programmer pins
    output var logic modResetN,
    output var logic progEnN,
    output var logic selN,
    output var logic sclk,
    output var logic sdat
);
    initial {modResetN, progEnN, selN, sclk, sdat} = 5'h1c;
    task automatic enter();
        progEnN = 1'b0;
        #3 modResetN = 1'b0;
        #125000;
    endtask : enter
    task automatic send(input logic [7:0] b);
        selN = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #40 sdat = b[i];
            #22.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        #20 selN = 1'b1;
        // Released line shows a changed level, never the last bit
        sdat = ~sdat;
    endtask : send
    task automatic leave();
        #10000 {modResetN, progEnN} = 2'h3;
    endtask : leave
endmodule : fpe_prog_model
`default_nettype wire

/* verification/flash_program_port_entry_tb_top.sv */
// Top bench: programmer model, op stimulus, queued done and bit checks.
// Assumes fpe_top with shortened op counts and two banks.
`timescale 1ns/1ps
`default_nettype none
module flash_program_port_entry_tb_top;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] opStart = 2'h0;
    logic [1:0] opKind = 2'h0;
    logic rN, eN, sN, sc, sd, pm, ch, se, sb;
    logic [1:0] bb, fs, od;
    int cyc = 0;
    int err_total = 0;
    int check_count = 0;
    int lt[4] = '{0, 20, 50, 60};
    int dq[$];
    logic bq[$];
    logic [31:0] rs = 32'hf56f;
    initial forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    fpe_prog_model pm_u (.modResetN(rN), .progEnN(eN), .selN(sN), .sclk(sc), .sdat(sd));
    fpe_top #(.WRITE_CYC(20), .PAGE_CYC(50), .MASS_CYC(60)) dut_u (.core_clk(core_clk),
        .arst_n(arst_n), .module_reset_n(rN), .flash_program_enable_n(eN),
        .prog_port_select_n(sN), .prog_port_serial_clock(sc), .prog_port_data_in(sd),
        .opStart(opStart), .opKind(opKind), .progMode(pm), .cpuHold(ch), .bankBusy(bb),
        .fetchStall(fs), .opDone(od), .serialEdge(se), .serialBit(sb));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (e !== s) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    always @(negedge core_clk) begin
        for (int b = 0; b < 2; b++)
            if (od[b] === 1'b1) chk("done", dq.size() ? dq.pop_front() : -1, cyc * 2 + b);
        if (se === 1'b1) chk("bit", bq.size() ? bq.pop_front() : 1'bx, sb);
    end
    task automatic op(input int b, input logic [1:0] k, input int n);
        @(negedge core_clk);
        opStart[b] = 1'b1;
        opKind = k;
        dq.push_back((cyc + n + 1) * 2 + b);
        #1 chk("stall", 1'b1, fs[b]);
        @(negedge core_clk);
        opKind = 2'h3;
        chk("busy", 1'b1, bb[b]);
        @(negedge core_clk);
        opStart[b] = 1'b0;
        for (int i = 0; i < 200 && dq.size() > 0; i++) @(negedge core_clk);
        if (dq.size() > 0) begin
            err_total++;
            conclude();
        end
        $display("op %0d on bank %0d over", k, b);
    endtask : op
    initial begin
        repeat (8) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        pm_u.enter();
        chk("mode", 2'h3, {pm, ch});
        for (int k = 0; k < 4; k++) op(k % 2, 2'(k % 3 + 1), lt[k % 3 + 1]);
        // Kind zero must leave the bank idle
        {opStart, opKind} = 4'h8;
        @(negedge core_clk);
        opStart = 2'h0;
        chk("idle", 2'h0, bb);
        $display("kind zero test over");
        repeat (3) begin
            rs = xs(rs);
            for (int i = 7; i >= 0; i--) bq.push_back(rs[i]);
            pm_u.send(rs[7:0]);
        end
        repeat (4) @(negedge core_clk);
        chk("bits", 0, bq.size());
        $display("serial test over");
        pm_u.leave();
        repeat (8) @(negedge core_clk);
        chk("mode", 2'h0, {pm, ch});
        $display("exit test over");
        conclude();
    end
endmodule : flash_program_port_entry_tb_top
bind fpe_top fpe_top_chk #(.WRITE_CYC(WRITE_CYC), .PAGE_CYC(PAGE_CYC),
    .MASS_CYC(MASS_CYC)) chk_u (.*);
`default_nettype wire
